// File: common/xtd_pkg.sv
// Constants for the test, exclusive-or, trap and relative-branch execution unit
// Operation
// - Each flag per instruction is set from result, kept, undefined, zeroed or forced one
// - Exclusive-or at B2-B7 and B8-B9 stores result; zero, sign follow; overflow cleared
// - Vector call F2: push program counter, then flags, then load counter from vector
// - Relative displacement is an 8-bit signed value, sign-extended before adding
// - Prefix byte 1F selects the second opcode map for the following opcode
package xtd_pkg;

  // Opcodes
  localparam logic [7:0] OP_PREFIX2   = 8'h1f;
  localparam logic [7:0] OP_WATCHDOG  = 8'h5f;
  localparam logic [7:0] OP_TRAP      = 8'hf2;
  localparam logic [7:0] OP_REL_JUMP  = 8'h8b;
  localparam logic [3:0] GRP_TEST     = 4'h7;
  localparam logic [3:0] GRP_XOR      = 4'hb;
  localparam logic [3:0] WORK_ESCAPE  = 4'he;

  // Values after reset
  localparam logic [15:0] PC_RESET    = 16'h0000;
  localparam logic [11:0] SP_RESET    = 12'h000;
  localparam logic [7:0]  FLAGS_RESET = 8'h00;

  // Stack pointer steps of the vector call
  localparam logic [11:0] SP_PC_STEP  = 12'h002;
  localparam logic [11:0] SP_FL_STEP  = 12'h001;

  // Flag positions
  localparam int FLAG_C = 7;
  localparam int FLAG_Z = 6;
  localparam int FLAG_S = 5;
  localparam int FLAG_V = 4;
  localparam int FLAG_D = 3;
  localparam int FLAG_H = 2;

  // Per-flag actions
  typedef enum logic [2:0] {
    XTD_FL_RESULT = 3'b000,
    XTD_FL_KEEP   = 3'b001,
    XTD_FL_UNDEF  = 3'b010,
    XTD_FL_ZERO   = 3'b011,
    XTD_FL_ONE    = 3'b100
  } xtd_flag_act_t;

  // Actions of the logic group, index is flag position
  localparam logic [7:0][2:0] LOGIC_ACTS = {
    XTD_FL_KEEP, XTD_FL_RESULT, XTD_FL_RESULT, XTD_FL_ZERO,
    XTD_FL_KEEP, XTD_FL_KEEP, XTD_FL_KEEP, XTD_FL_KEEP
  };

endpackage : xtd_pkg

// File: verilog/xtd_flag_unit.sv
// Logic unit: AND or exclusive-or with per-flag update actions
`timescale 1ns/1ns
`default_nettype none
module xtd_flag_unit (
  // Operands
  input  wire logic [7:0]      dst_i,
  input  wire logic [7:0]      src_i,
  input  wire logic            op_xor_i,
  // Flags
  input  wire logic [7:0]      flags_i,
  input  wire logic [7:0][2:0] acts_i,
  output logic      [7:0]      result_o,
  output logic      [7:0]      flags_o
);

  logic [7:0] res_bits;

  assign result_o = op_xor_i ? (dst_i ^ src_i) : (dst_i & src_i);

  // Result-derived value of zero, sign and overflow; the other flags pass through from flags_i
  always_comb begin
    res_bits                 = flags_i;
    res_bits[xtd_pkg::FLAG_Z] = (result_o == 8'h00);
    res_bits[xtd_pkg::FLAG_S] = result_o[7];
    res_bits[xtd_pkg::FLAG_V] = 1'b0;
  end

  genvar g;
  generate
    for (g = 0; g < 8; g++) begin : g_flag
      always_comb begin
        case (acts_i[g])
          xtd_pkg::XTD_FL_RESULT: flags_o[g] = res_bits[g];
          xtd_pkg::XTD_FL_ZERO:   flags_o[g] = 1'b0;
          xtd_pkg::XTD_FL_ONE:    flags_o[g] = 1'b1;
          default:                flags_o[g] = flags_i[g];
        endcase
      end
    end
  endgenerate

endmodule : xtd_flag_unit
`default_nettype wire

// File: verilog/xtd_core.sv
// Execution unit for test-under-mask, exclusive-or, trap, relative jump and prefix
`timescale 1ns/1ns
`default_nettype none
module xtd_core (
  // Clock and reset
  input  wire logic        clock_i,
  input  wire logic        reset_n_i,
  // Register pointer
  input  wire logic [7:0]  reg_ptr_i,
  // Memory port, read data valid the cycle after a read strobe
  output logic      [15:0] mem_addr_o,
  output logic             mem_prog_o,
  output logic             mem_rd_o,
  output logic             mem_wr_o,
  output logic      [7:0]  mem_wdata_o,
  input  wire logic [7:0]  mem_rdata_i,
  // Status
  output logic      [15:0] pc_o,
  output logic      [11:0] sp_o,
  output logic      [7:0]  flags_o,
  output logic             instr_done_o,
  output logic             unsupported_o,
  output logic             watchdog_refresh_op_o
);

  typedef enum logic [4:0] {
    S_FETCH = 5'h00, S_WAIT  = 5'h01, S_DEC   = 5'h02, S_OPRD  = 5'h03,
    S_OPCAP = 5'h04, S_DISP  = 5'h05, S_PTR   = 5'h06, S_PTRC  = 5'h07,
    S_RDS   = 5'h08, S_CAPS  = 5'h09, S_RDD   = 5'h0a, S_EXE   = 5'h0b,
    S_TR1   = 5'h0c, S_TR2   = 5'h0d, S_TR3   = 5'h0e, S_TR4   = 5'h0f,
    S_TR5   = 5'h10
  } xtd_state_t;

  typedef struct packed {
    xtd_state_t      st, ret;
    logic [15:0]     pc;
    logic [11:0]     sp;
    logic [7:0]      flags;
    logic            map2;
    logic [7:0]      op;
    logic [2:0][7:0] opb;
    logic [1:0]      cnt, idx;
    logic [11:0]     src_a, dst_a;
    logic [7:0]      src_v;
    logic            src_ind, dst_ind, use_imm;
    logic [15:0]     mem_addr;
    logic            mem_prog, mem_rd, mem_wr;
    logic [7:0]      mem_wdata;
    logic            done, unsup, wdt;
  } xtd_regs_t;

  xtd_regs_t  r_r, r_nxt;
  logic [7:0] alu_res, alu_flags;

  // Working register address
  function automatic logic [11:0] work_addr(input logic [7:0] rp, input logic [3:0] n);
    work_addr = {rp[3:0], rp[7:4], n};
  endfunction : work_addr
  // 8-bit register address, with the working-register escape
  function automatic logic [11:0] reg_addr(input logic [7:0] rp, input logic [7:0] a);
    if (a[7:4] == xtd_pkg::WORK_ESCAPE) begin
      reg_addr = work_addr(rp, a[3:0]);
    end else begin
      reg_addr = {rp[3:0], a};
    end
  endfunction : reg_addr
  // Operand bytes after the opcode, zero for opcodes not handled here
  function automatic logic [1:0] opnd_count(input logic [7:0] op);
    if (op == xtd_pkg::OP_TRAP || op == xtd_pkg::OP_REL_JUMP) begin
      opnd_count = 2'd1;
    end else if (op[7:4] == xtd_pkg::GRP_TEST || op[7:4] == xtd_pkg::GRP_XOR) begin
      case (op[3:0])
        4'h2, 4'h3:             opnd_count = 2'd1;
        4'h4, 4'h5, 4'h6, 4'h7: opnd_count = 2'd2;
        4'h8, 4'h9:             opnd_count = 2'd3;
        default:                opnd_count = 2'd0;
      endcase
    end else begin
      opnd_count = 2'd0;
    end
  endfunction : opnd_count

  xtd_flag_unit u_flag_unit (
    .dst_i    (mem_rdata_i),
    .src_i    (r_r.src_v),
    .op_xor_i (r_r.op[7:4] == xtd_pkg::GRP_XOR),
    .flags_i  (r_r.flags),
    .acts_i   (xtd_pkg::LOGIC_ACTS),
    .result_o (alu_res),
    .flags_o  (alu_flags)
  );

  always_comb begin
    r_nxt        = r_r;
    r_nxt.mem_rd = 1'b0;
    r_nxt.mem_wr = 1'b0;
    r_nxt.done   = 1'b0;
    r_nxt.unsup  = 1'b0;
    r_nxt.wdt    = 1'b0;
    case (r_r.st)
      S_FETCH: begin
        r_nxt.mem_addr = r_r.pc;
        r_nxt.mem_prog = 1'b1;
        r_nxt.mem_rd   = 1'b1;
        r_nxt.pc       = r_r.pc + 16'h0001;
        r_nxt.ret      = S_DEC;
        r_nxt.st       = S_WAIT;
      end
      S_WAIT: r_nxt.st = r_r.ret;
      S_DEC: begin
        r_nxt.op  = mem_rdata_i;
        r_nxt.idx = 2'd0;
        r_nxt.cnt = opnd_count(mem_rdata_i);
        r_nxt.st  = S_FETCH;
        if (r_r.map2) begin
          r_nxt.map2  = 1'b0;
          r_nxt.unsup = 1'b1;
          r_nxt.done  = 1'b1;
        end else if (mem_rdata_i == xtd_pkg::OP_PREFIX2) begin
          r_nxt.map2 = 1'b1;
        end else if (mem_rdata_i == xtd_pkg::OP_WATCHDOG) begin
          r_nxt.wdt  = 1'b1;
          r_nxt.done = 1'b1;
        end else if (opnd_count(mem_rdata_i) == 2'd0) begin
          r_nxt.unsup = 1'b1;
          r_nxt.done  = 1'b1;
        end else begin
          r_nxt.st = S_OPRD;
        end
      end
      S_OPRD: begin
        r_nxt.mem_addr = r_r.pc;
        r_nxt.mem_prog = 1'b1;
        r_nxt.mem_rd   = 1'b1;
        r_nxt.pc       = r_r.pc + 16'h0001;
        r_nxt.ret      = S_OPCAP;
        r_nxt.st       = S_WAIT;
      end
      S_OPCAP: begin
        r_nxt.opb[r_r.idx] = mem_rdata_i;
        r_nxt.idx          = r_r.idx + 2'd1;
        r_nxt.st           = (r_r.idx + 2'd1 == r_r.cnt) ? S_DISP : S_OPRD;
      end
      S_DISP: begin
        r_nxt.src_ind = 1'b0;
        r_nxt.dst_ind = 1'b0;
        r_nxt.use_imm = 1'b0;
        r_nxt.st      = S_PTR;
        if (r_r.op == xtd_pkg::OP_TRAP) begin
          r_nxt.sp        = r_r.sp - xtd_pkg::SP_PC_STEP;
          r_nxt.mem_addr  = {4'h0, r_r.sp - xtd_pkg::SP_PC_STEP};
          r_nxt.mem_prog  = 1'b0;
          r_nxt.mem_wr    = 1'b1;
          r_nxt.mem_wdata = r_r.pc[15:8];
          r_nxt.st        = S_TR1;
        end else if (r_r.op == xtd_pkg::OP_REL_JUMP) begin
          r_nxt.pc   = r_r.pc + {{8{r_r.opb[0][7]}}, r_r.opb[0]};
          r_nxt.done = 1'b1;
          r_nxt.st   = S_FETCH;
        end else begin
          case (r_r.op[3:0])
            4'h2: begin
              r_nxt.dst_a = work_addr(reg_ptr_i, r_r.opb[0][7:4]);
              r_nxt.src_a = work_addr(reg_ptr_i, r_r.opb[0][3:0]);
            end
            4'h3: begin
              r_nxt.dst_a   = work_addr(reg_ptr_i, r_r.opb[0][7:4]);
              r_nxt.src_a   = work_addr(reg_ptr_i, r_r.opb[0][3:0]);
              r_nxt.src_ind = 1'b1;
            end
            4'h4, 4'h5: begin
              r_nxt.src_a   = reg_addr(reg_ptr_i, r_r.opb[0]);
              r_nxt.dst_a   = reg_addr(reg_ptr_i, r_r.opb[1]);
              r_nxt.src_ind = r_r.op[0];
            end
            4'h6, 4'h7: begin
              r_nxt.dst_a   = reg_addr(reg_ptr_i, r_r.opb[0]);
              r_nxt.src_v   = r_r.opb[1];
              r_nxt.use_imm = 1'b1;
              r_nxt.dst_ind = r_r.op[0];
            end
            4'h8: begin
              r_nxt.src_a = {r_r.opb[0], r_r.opb[1][7:4]};
              r_nxt.dst_a = {r_r.opb[1][3:0], r_r.opb[2]};
            end
            default: begin
              r_nxt.src_v   = r_r.opb[0];
              r_nxt.use_imm = 1'b1;
              r_nxt.dst_a   = {r_r.opb[1][3:0], r_r.opb[2]};
            end
          endcase
        end
      end
      S_PTR: begin
        r_nxt.mem_prog = 1'b0;
        r_nxt.mem_addr = {4'h0, r_r.src_ind ? r_r.src_a : r_r.dst_a};
        r_nxt.mem_rd   = r_r.src_ind | r_r.dst_ind;
        r_nxt.ret      = S_PTRC;
        r_nxt.st       = (r_r.src_ind | r_r.dst_ind) ? S_WAIT : S_RDS;
      end
      S_PTRC: begin
        if (r_r.src_ind) begin
          r_nxt.src_a   = reg_addr(reg_ptr_i, mem_rdata_i);
          r_nxt.src_ind = 1'b0;
        end else begin
          r_nxt.dst_a   = reg_addr(reg_ptr_i, mem_rdata_i);
          r_nxt.dst_ind = 1'b0;
        end
        r_nxt.st = S_PTR;
      end
      S_RDS: begin
        r_nxt.mem_prog = 1'b0;
        r_nxt.mem_addr = {4'h0, r_r.src_a};
        r_nxt.mem_rd   = !r_r.use_imm;
        r_nxt.ret      = S_CAPS;
        r_nxt.st       = r_r.use_imm ? S_RDD : S_WAIT;
      end
      S_CAPS: begin
        r_nxt.src_v = mem_rdata_i;
        r_nxt.st    = S_RDD;
      end
      S_RDD: begin
        r_nxt.mem_prog = 1'b0;
        r_nxt.mem_addr = {4'h0, r_r.dst_a};
        r_nxt.mem_rd   = 1'b1;
        r_nxt.ret      = S_EXE;
        r_nxt.st       = S_WAIT;
      end
      S_EXE: begin
        r_nxt.flags     = alu_flags;
        r_nxt.mem_prog  = 1'b0;
        r_nxt.mem_addr  = {4'h0, r_r.dst_a};
        r_nxt.mem_wdata = alu_res;
        r_nxt.mem_wr    = (r_r.op[7:4] == xtd_pkg::GRP_XOR);
        r_nxt.done      = 1'b1;
        r_nxt.st        = S_FETCH;
      end
      S_TR1: begin
        r_nxt.mem_addr  = {4'h0, r_r.sp + 12'h001};
        r_nxt.mem_wr    = 1'b1;
        r_nxt.mem_wdata = r_r.pc[7:0];
        r_nxt.st        = S_TR2;
      end
      S_TR2: begin
        r_nxt.sp        = r_r.sp - xtd_pkg::SP_FL_STEP;
        r_nxt.mem_addr  = {4'h0, r_r.sp - xtd_pkg::SP_FL_STEP};
        r_nxt.mem_wr    = 1'b1;
        r_nxt.mem_wdata = r_r.flags;
        r_nxt.st        = S_TR3;
      end
      S_TR3: begin
        r_nxt.mem_addr = {7'h00, r_r.opb[0], 1'b0};
        r_nxt.mem_prog = 1'b1;
        r_nxt.mem_rd   = 1'b1;
        r_nxt.ret      = S_TR4;
        r_nxt.st       = S_WAIT;
      end
      S_TR4: begin
        r_nxt.src_v    = mem_rdata_i;
        r_nxt.mem_addr = {7'h00, r_r.opb[0], 1'b1};
        r_nxt.mem_rd   = 1'b1;
        r_nxt.ret      = S_TR5;
        r_nxt.st       = S_WAIT;
      end
      S_TR5: begin
        r_nxt.pc   = {r_r.src_v, mem_rdata_i};
        r_nxt.done = 1'b1;
        r_nxt.st   = S_FETCH;
      end
      default: r_nxt.st = S_FETCH;
    endcase
  end

  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      r_r       <= '0;
      r_r.pc    <= xtd_pkg::PC_RESET;
      r_r.sp    <= xtd_pkg::SP_RESET;
      r_r.flags <= xtd_pkg::FLAGS_RESET;
    end else begin
      r_r <= r_nxt;
    end
  end

  assign mem_addr_o            = r_r.mem_addr;
  assign mem_prog_o            = r_r.mem_prog;
  assign mem_rd_o              = r_r.mem_rd;
  assign mem_wr_o              = r_r.mem_wr;
  assign mem_wdata_o           = r_r.mem_wdata;
  assign pc_o                  = r_r.pc;
  assign sp_o                  = r_r.sp;
  assign flags_o               = r_r.flags;
  assign instr_done_o          = r_r.done;
  assign unsupported_o         = r_r.unsup;
  assign watchdog_refresh_op_o = r_r.wdt;

endmodule : xtd_core
`default_nettype wire

// File: verification/xtd_core_sva.sv
// Assertions on the ports of the execution unit
`timescale 1ns/1ns
`default_nettype none
module xtd_core_sva (
  // Clock and reset
  input wire logic        clock_i,
  input wire logic        reset_n_i,
  // Register pointer and memory port
  input wire logic [7:0]  reg_ptr_i,
  input wire logic [15:0] mem_addr_o,
  input wire logic        mem_prog_o,
  input wire logic        mem_rd_o,
  input wire logic        mem_wr_o,
  input wire logic [7:0]  mem_wdata_o,
  input wire logic [7:0]  mem_rdata_i,
  // Status
  input wire logic [15:0] pc_o,
  input wire logic [11:0] sp_o,
  input wire logic [7:0]  flags_o,
  input wire logic        instr_done_o,
  input wire logic        unsupported_o,
  input wire logic        watchdog_refresh_op_o
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!reset_n_i);
  // Three back-to-back stack writes of the vector call
  sequence trap_writes;
    mem_wr_o && !$past(mem_wr_o) ##1 mem_wr_o ##1 mem_wr_o;
  endsequence
  a_xor_flags: assert property (
    mem_wr_o && instr_done_o |-> flags_o[6] == (mem_wdata_o == 8'h00)
      && flags_o[5] == mem_wdata_o[7] && !flags_o[4])
    else $error("flags do not follow stored result");
  a_flags_at_done: assert property (
    $changed(flags_o) |-> instr_done_o)
    else $error("flags changed outside completion");
  a_kept_flags: assert property (
    instr_done_o |-> $stable({flags_o[7], flags_o[3:2]}))
    else $error("carry, decimal or half flag changed");
  a_zero_sign: assert property (
    instr_done_o |-> !(flags_o[6] && flags_o[5]) && !flags_o[4])
    else $error("zero and sign flags inconsistent");
  a_trap_push: assert property (
    trap_writes |-> mem_addr_o[11:0] == $past(mem_addr_o[11:0], 2) - 12'h001
      && $past(mem_addr_o[11:0]) == $past(mem_addr_o[11:0], 2) + 12'h001
      && mem_wdata_o == flags_o && sp_o == mem_addr_o[11:0] && !mem_prog_o)
    else $error("stack push order wrong");
  a_trap_vector: assert property (
    trap_writes |-> ##[1:4] (mem_rd_o && mem_prog_o && !mem_addr_o[0]))
    else $error("vector read missing");
  a_second_map: assert property (
    unsupported_o |-> instr_done_o && !mem_wr_o)
    else $error("second map opcode not completed cleanly");
endmodule : xtd_core_sva
bind xtd_core xtd_core_sva i_xtd_core_sva (.clock_i(clock_i), .reset_n_i(reset_n_i),
  .reg_ptr_i(reg_ptr_i), .mem_addr_o(mem_addr_o), .mem_prog_o(mem_prog_o),
  .mem_rd_o(mem_rd_o), .mem_wr_o(mem_wr_o), .mem_wdata_o(mem_wdata_o),
  .mem_rdata_i(mem_rdata_i), .pc_o(pc_o), .sp_o(sp_o), .flags_o(flags_o),
  .instr_done_o(instr_done_o), .unsupported_o(unsupported_o),
  .watchdog_refresh_op_o(watchdog_refresh_op_o));
`default_nettype wire

// File: verification/xtd_mem_model.sv
// Program memory and register file answering one cycle after a read
`timescale 1ns/1ns
`default_nettype none
module xtd_mem_model (
  // Clock
  input  wire logic        clock_i,
  // Memory port
  input  wire logic [15:0] mem_addr_i,
  input  wire logic        mem_prog_i,
  input  wire logic        mem_rd_i,
  input  wire logic        mem_wr_i,
  input  wire logic [7:0]  mem_wdata_i,
  output logic      [7:0]  mem_rdata_o
);
  logic [7:0] pmem [0:255];
  logic [7:0] rmem [0:4095];
  logic       valid_r;
  initial begin
    mem_rdata_o = 8'h00;
    valid_r = 1'b0;
  end
  always @(posedge clock_i) begin
    valid_r <= mem_rd_i;
    if (mem_rd_i)
      mem_rdata_o <= mem_prog_i ? pmem[mem_addr_i[7:0]] : rmem[mem_addr_i[11:0]];
    else if (valid_r)
      mem_rdata_o <= ~mem_rdata_o;
    if (mem_wr_i && mem_prog_i)
      pmem[mem_addr_i[7:0]] <= mem_wdata_i;
    if (mem_wr_i && !mem_prog_i)
      rmem[mem_addr_i[11:0]] <= mem_wdata_i;
  end
endmodule : xtd_mem_model
`default_nettype wire

// File: verification/test_cpu_xor_test_trap_decode.sv
// Self-checking bench running one program through the execution unit
`timescale 1ns/1ns
`default_nettype none
module test_cpu_xor_test_trap_decode;
  logic        clock_i;
  logic        reset_n_i;
  logic [7:0]  reg_ptr_i;
  logic [15:0] mem_addr_o;
  logic        mem_prog_o;
  logic        mem_rd_o;
  logic        mem_wr_o;
  logic [7:0]  mem_wdata_o;
  logic [7:0]  mem_rdata_i;
  logic [15:0] pc_o;
  logic [11:0] sp_o;
  logic [7:0]  flags_o;
  logic        instr_done_o;
  logic        unsupported_o;
  logic        watchdog_refresh_op_o;
  int          fails;
  int          checks_done;

  xtd_core i_xtd_core (.clock_i(clock_i), .reset_n_i(reset_n_i), .reg_ptr_i(reg_ptr_i),
    .mem_addr_o(mem_addr_o), .mem_prog_o(mem_prog_o), .mem_rd_o(mem_rd_o),
    .mem_wr_o(mem_wr_o), .mem_wdata_o(mem_wdata_o), .mem_rdata_i(mem_rdata_i),
    .pc_o(pc_o), .sp_o(sp_o), .flags_o(flags_o), .instr_done_o(instr_done_o),
    .unsupported_o(unsupported_o), .watchdog_refresh_op_o(watchdog_refresh_op_o));
  xtd_mem_model i_xtd_mem_model (.clock_i(clock_i), .mem_addr_i(mem_addr_o),
    .mem_prog_i(mem_prog_o), .mem_rd_i(mem_rd_o), .mem_wr_i(mem_wr_o),
    .mem_wdata_i(mem_wdata_o), .mem_rdata_o(mem_rdata_i));

  always #2 clock_i = ~clock_i;

  task chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk

  task wait_done;
    int n;
    n = 0;
    do begin
      @(negedge clock_i);
      n++;
    end while (instr_done_o !== 1'b1 && n < 40);
    chk(16'(instr_done_o), 16'h0001, "completion");
  endtask : wait_done

  task load(input int a, input logic [7:0] b [$]);
    foreach (b[i]) i_xtd_mem_model.pmem[a + i] = b[i];
  endtask : load

  task test_xor_reg;
    wait_done;
    chk(16'(flags_o), 16'h0040, "xor flags");
    chk(16'(mem_wr_o), 16'h0001, "xor store");
    chk(16'(mem_addr_o), 16'h0121, "xor address");
    $display("test xor_reg done");
  endtask : test_xor_reg

  task test_jump(input logic [15:0] target);
    wait_done;
    chk(pc_o, target, "jump target");
    $display("test jump done");
  endtask : test_jump

  task test_tm(input logic [7:0] fl, input logic [11:0] a, input logic [7:0] d);
    wait_done;
    chk(16'(flags_o), 16'(fl), "test flags");
    chk(16'(mem_wr_o), 16'h0000, "test no store");
    @(negedge clock_i);
    chk(16'(i_xtd_mem_model.rmem[a]), 16'(d), "test operand kept");
    $display("test tm done");
  endtask : test_tm

  task test_xor_ext;
    wait_done;
    chk(16'(flags_o), 16'h0020, "extended_exclusive_or flags");
    chk(16'(mem_wdata_o), 16'h00ff, "extended_exclusive_or result");
    chk(mem_addr_o, 16'h0367, "extended_exclusive_or address");
    $display("test xor_ext done");
  endtask : test_xor_ext

  task test_wdog_prefix;
    wait_done;
    chk(16'(watchdog_refresh_op_o), 16'h0001, "refresh op");
    chk(16'(flags_o), 16'h0040, "flags kept");
    wait_done;
    chk(16'(unsupported_o), 16'h0001, "second map");
    chk(pc_o, 16'h002d, "second map skip");
    $display("test wdog_prefix done");
  endtask : test_wdog_prefix

  task test_trap;
    wait_done;
    chk(pc_o, 16'h0040, "vector");
    chk(16'(sp_o), 16'h0ffd, "stack pointer");
    chk(16'(i_xtd_mem_model.rmem[12'hffe]), 16'h0000, "pc high");
    chk(16'(i_xtd_mem_model.rmem[12'hfff]), 16'h0006, "pc low");
    chk(16'(i_xtd_mem_model.rmem[12'hffd]), 16'h0040, "flags");
    $display("test trap done");
  endtask : test_trap

  task test_forms;
    wait_done;
    chk(16'(flags_o), 16'h0020, "xor indirect flags");
    chk(mem_addr_o, 16'h0125, "xor indirect address");
    chk(16'(mem_wdata_o), 16'h00ff, "xor indirect result");
    wait_done;
    chk(16'(flags_o), 16'h0000, "test indirect flags");
    chk(16'(mem_wr_o), 16'h0000, "test indirect no store");
    chk(16'(i_xtd_mem_model.rmem[12'h125]), 16'h00ff, "xor indirect stored");
    wait_done;
    chk(16'(flags_o), 16'h0040, "xor immediate flags");
    chk(16'(mem_wr_o), 16'h0001, "xor immediate store");
    chk(mem_addr_o, 16'h0135, "xor immediate address");
    wait_done;
    chk(16'(flags_o), 16'h0000, "xor escape flags");
    chk(mem_addr_o, 16'h0138, "xor escape address");
    chk(16'(mem_wdata_o), 16'h0001, "xor escape result");
    wait_done;
    chk(16'(flags_o), 16'h0020, "test ext flags");
    chk(16'(mem_wr_o), 16'h0000, "test ext no store");
    wait_done;
    chk(16'(unsupported_o), 16'h0001, "unknown opcode");
    chk(16'(flags_o), 16'h0020, "flags kept");
    chk(16'(i_xtd_mem_model.rmem[12'h133]), 16'h0081, "test operand kept");
    $display("test forms done");
  endtask : test_forms

  task tally_and_finish;
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : tally_and_finish

  initial begin
    #20000;
    fails++;
    tally_and_finish;
  end

  initial begin
    clock_i = 1'b0;
    reset_n_i = 1'b0;
    reg_ptr_i = 8'h21;
    fails = 0;
    checks_done = 0;
    for (int i = 0; i < 256; i++) i_xtd_mem_model.pmem[i] = 8'h00;
    load(0, {8'hb2, 8'h12, 8'h8b, 8'h1c, 8'hf2, 8'h08});
    load(16, {8'h00, 8'h40});
    load(32, {8'h72, 8'h34, 8'hb8, 8'h34, 8'h53, 8'h67, 8'h79, 8'h0f});
    load(40, {8'h03, 8'h89, 8'h5f, 8'h1f, 8'h10, 8'h8b, 8'hd5});
    i_xtd_mem_model.rmem[12'h121] = 8'h5a;
    i_xtd_mem_model.rmem[12'h122] = 8'h5a;
    i_xtd_mem_model.rmem[12'h123] = 8'hf0;
    i_xtd_mem_model.rmem[12'h124] = 8'h80;
    i_xtd_mem_model.rmem[12'h345] = 8'h0f;
    i_xtd_mem_model.rmem[12'h367] = 8'hf0;
    i_xtd_mem_model.rmem[12'h389] = 8'hf0;
    load(64, {8'hb3, 8'h56, 8'h75, 8'h31, 8'h32, 8'hb7, 8'h34, 8'haa, 8'hb4, 8'he7,
              8'h38, 8'h78, 8'h45, 8'h64, 8'h57, 8'h00});
    i_xtd_mem_model.rmem[12'h125] = 8'hf0;
    i_xtd_mem_model.rmem[12'h126] = 8'h30;
    i_xtd_mem_model.rmem[12'h127] = 8'h3c;
    i_xtd_mem_model.rmem[12'h130] = 8'h0f;
    i_xtd_mem_model.rmem[12'h131] = 8'h33;
    i_xtd_mem_model.rmem[12'h132] = 8'h01;
    i_xtd_mem_model.rmem[12'h133] = 8'h81;
    i_xtd_mem_model.rmem[12'h134] = 8'h35;
    i_xtd_mem_model.rmem[12'h135] = 8'haa;
    i_xtd_mem_model.rmem[12'h138] = 8'h3d;
    i_xtd_mem_model.rmem[12'h456] = 8'h80;
    i_xtd_mem_model.rmem[12'h457] = 8'hc0;
    repeat (3) @(posedge clock_i);
    reset_n_i <= 1'b1;
    test_xor_reg;
    test_jump(16'h0020);
    chk(16'(i_xtd_mem_model.rmem[12'h121]), 16'h0000, "xor stored");
    test_tm(8'h20, 12'h123, 8'hf0);
    test_xor_ext;
    test_tm(8'h40, 12'h389, 8'hf0);
    test_wdog_prefix;
    test_jump(16'h0004);
    test_trap;
    test_forms;
    tally_and_finish;
  end
endmodule : test_cpu_xor_test_trap_decode
`default_nettype wire
